/* rtl/rdws_top.sv */
// Reset, factory restore, wake, standby and status indicator logic,
// plus direction control of the thirteen configurable pins.
// Assumes all inputs are synchronous to REF_CLK and firmware drives
// the pin and sleep controls.
//
// Function
// - Reboot after hardware reset held low 50ms
// - Restore held six seconds restores defaults, reboots
// - Restore input sampled by periodic polling
// - System indicator on; blinks after five seconds
// - Restore and reboot after button release
// - Wake rising edge leaves standby
// - Standby indicator asserted throughout standby
// - Wireless indicator lit while associated
// - Wireless indicator active low, system high
// - Speed indicator low at 100, high at 10
// - Link indicator low, toggles on activity
// - Thirteen configurable pins, inputs after reset
// - Pin two irq; three,four,seven,eight serial
`timescale 1ns/1ps
`include "rdws_consts.svh"

module rdws_top
  import rdws_pkg::*;
#(
  parameter logic [31:0] HW_REBOOT_CYC  = 32'(`RDWS_HW_REBOOT_CYC),
  parameter logic [31:0] POLL_CYC       = 32'(`RDWS_POLL_CYC),
  parameter logic [31:0] BLINK_HALF_CYC = 32'(`RDWS_BLINK_HALF_CYC)
) (
  input  wire logic       REF_CLK,
  input  wire logic       SRST,
  input  wire logic       HW_REBOOT_N,
  input  wire logic       FACTORY_RESTORE_N,
  input  wire logic       WAKE,
  input  wire logic       SLEEP_REQ,
  input  wire logic       STA_ASSOCIATED,
  input  wire rdws_net_s  NET_STATUS,
  input  wire logic       SPI_ENABLE,
  input  wire rdws_spi_s  SPI_OUT,
  input  wire rdws_pins_t PIN_DIR_OUT,
  input  wire rdws_pins_t PIN_DATA_OUT,
  input  wire rdws_pins_t CONFIGURABLE_PIN_I,
  output logic            CPU_RESET,
  output logic            RESTORE_DEFAULTS,
  output logic            STANDBY_INDICATOR,
  output logic            SYSTEM_INDICATOR,
  output logic            WIRELESS_INDICATOR_N,
  output logic            NET_SPEED_INDICATOR_N,
  output logic            NET_LINK_ACTIVITY_INDICATOR_N,
  output rdws_pins_t      CONFIGURABLE_PIN_O,
  output rdws_pins_t      CONFIGURABLE_PIN_OE_N,
  output rdws_pins_t      PIN_DATA_IN,
  output logic            CONFIGURABLE_PIN_IRQ,
  output logic            SPI_MISO
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [9:0] RESTORE_POLLS = 10'(`RDWS_RESTORE_POLLS);
  localparam logic [9:0] BLINK_POLLS   = 10'(`RDWS_BLINK_POLLS);
  localparam logic [4:0] PULSE_LAST    = 5'(`RDWS_REBOOT_PULSE_CYC - 1);

  rdws_state_e state_reg,     state_next;
  logic [31:0] hw_cnt_reg,    hw_cnt_next;
  logic [31:0] poll_cnt_reg,  poll_cnt_next;
  logic        samp_reg,      samp_next;
  logic        held_reg,      held_next;
  logic [9:0]  hold_reg,      hold_next;
  logic [4:0]  pulse_reg,     pulse_next;
  logic        wake_prev_reg, wake_prev_next;
  logic [31:0] blink_cnt_reg, blink_cnt_next;
  logic        phase_reg,     phase_next;
  logic        act_tog_reg,   act_tog_next;
  logic        blinking;
  logic        poll_tick;

  logic        cpu_rst_next, restore_next, standby_next;
  logic        sys_ind_next, wifi_n_next, speed_n_next, link_n_next;
  rdws_pins_t  pin_o_next, pin_oe_n_next, pin_in_next;
  logic        irq_next, miso_next;

  // ****************************************************************
  // Restore input polling and hold measurement
  // ****************************************************************
  // Sampled only on poll ticks; two equal samples in a row are needed,
  // so a bounce shorter than one interval neither starts nor ends a hold
  always_comb begin
    poll_tick     = (poll_cnt_reg == POLL_CYC - 32'h1);
    poll_cnt_next = poll_tick ? 32'h0 : poll_cnt_reg + 32'h1;
    samp_next     = samp_reg;
    held_next     = held_reg;
    hold_next     = hold_reg;
    if (poll_tick) begin
      samp_next = FACTORY_RESTORE_N;
      if (samp_reg == FACTORY_RESTORE_N) begin
        held_next = ~FACTORY_RESTORE_N;
      end
      if (!held_reg) begin
        hold_next = 10'h0;
      end else if (hold_reg != RESTORE_POLLS) begin
        hold_next = hold_reg + 10'h1;
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Hardware reboot has top priority, even over a running restore
  always_comb begin
    state_next     = state_reg;
    pulse_next     = pulse_reg;
    wake_prev_next = WAKE;
    hw_cnt_next    = 32'h0;
    if (!HW_REBOOT_N) begin
      hw_cnt_next = (hw_cnt_reg == HW_REBOOT_CYC - 32'h1) ?
                    hw_cnt_reg : hw_cnt_reg + 32'h1;
    end
    case (state_reg)
      S_RUN: begin
        if (held_reg && hold_reg == RESTORE_POLLS) begin
          state_next = S_ARMED;
        end else if (SLEEP_REQ) begin
          state_next = S_STANDBY;
        end
      end
      S_ARMED: begin
        if (!held_reg) begin
          state_next = S_RESTORE;
        end
      end
      S_RESTORE: begin
        state_next = S_REBOOT;
        pulse_next = 5'h0;
      end
      S_REBOOT: begin
        pulse_next = pulse_reg + 5'h1;
        if (pulse_reg == PULSE_LAST) begin
          state_next = S_RUN;
        end
      end
      S_STANDBY: begin
        if (WAKE && !wake_prev_reg) begin
          state_next = S_RUN;
        end
      end
      S_HWRST: begin
        if (HW_REBOOT_N) begin
          state_next = S_RUN;
        end
      end
      default: state_next = S_RUN;
    endcase
    if (!HW_REBOOT_N && hw_cnt_reg == HW_REBOOT_CYC - 32'h1) begin
      state_next = S_HWRST;
    end
    cpu_rst_next = (state_next == S_HWRST) ||
                   (state_next == S_REBOOT);
    restore_next = (state_next == S_RESTORE);
    standby_next = (state_next == S_STANDBY);
  end

  // ****************************************************************
  // Status indicators
  // ****************************************************************
  // Blink starts dark so the first change is seen at once
  always_comb begin
    blinking = (held_reg && hold_reg >= BLINK_POLLS) ||
               (state_reg == S_ARMED);
    blink_cnt_next = 32'h0;
    phase_next     = 1'b0;
    if (blinking) begin
      phase_next     = phase_reg;
      blink_cnt_next = blink_cnt_reg + 32'h1;
      if (blink_cnt_reg == BLINK_HALF_CYC - 32'h1) begin
        blink_cnt_next = 32'h0;
        phase_next     = ~phase_reg;
      end
    end
    sys_ind_next = blinking ? phase_next : 1'b1;
    wifi_n_next  = ~STA_ASSOCIATED;
    speed_n_next = ~(NET_STATUS.link_up & NET_STATUS.speed_100);
    act_tog_next = NET_STATUS.link_up &
                   (act_tog_reg ^ NET_STATUS.activity);
    link_n_next  = ~NET_STATUS.link_up | act_tog_next;
  end

  // ****************************************************************
  // Configurable pins
  // ****************************************************************
  // Serial roles override firmware direction on their pins
  for (genvar i = 0; i < `RDWS_PIN_COUNT; i++) begin : g_pin
    logic drive;
    logic level;
    always_comb begin
      drive = PIN_DIR_OUT[i];
      level = PIN_DATA_OUT[i];
      if (SPI_ENABLE) begin
        if (i == `RDWS_PIN_IRQ || i == `RDWS_PIN_MISO) begin
          drive = 1'b0;
        end else if (i == `RDWS_PIN_MOSI) begin
          drive = 1'b1;
          level = SPI_OUT.mosi;
        end else if (i == `RDWS_PIN_SCK) begin
          drive = 1'b1;
          level = SPI_OUT.sck;
        end else if (i == `RDWS_PIN_CS) begin
          drive = 1'b1;
          level = SPI_OUT.cs_n;
        end
      end
    end
    assign pin_oe_n_next[i] = ~drive;
    assign pin_o_next[i]    = level;
    assign pin_in_next[i]   = CONFIGURABLE_PIN_I[i];
  end

  always_comb begin
    irq_next  = SPI_ENABLE & CONFIGURABLE_PIN_I[`RDWS_PIN_IRQ];
    miso_next = SPI_ENABLE & CONFIGURABLE_PIN_I[`RDWS_PIN_MISO];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Pins leave reset released, so every pin is an input
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_reg      <= S_RUN;
      hw_cnt_reg     <= 32'h0;
      poll_cnt_reg   <= 32'h0;
      samp_reg       <= 1'b1;
      held_reg       <= 1'b0;
      hold_reg       <= 10'h0;
      pulse_reg      <= 5'h0;
      wake_prev_reg  <= 1'b0;
      blink_cnt_reg  <= 32'h0;
      phase_reg      <= 1'b0;
      act_tog_reg    <= 1'b0;
      CPU_RESET      <= 1'b0;
      RESTORE_DEFAULTS              <= 1'b0;
      STANDBY_INDICATOR             <= 1'b0;
      SYSTEM_INDICATOR              <= `RDWS_SYS_IND_RST;
      WIRELESS_INDICATOR_N          <= 1'b1;
      NET_SPEED_INDICATOR_N         <= 1'b1;
      NET_LINK_ACTIVITY_INDICATOR_N <= 1'b1;
      CONFIGURABLE_PIN_O            <= '0;
      CONFIGURABLE_PIN_OE_N         <= `RDWS_PINS_RST;
      PIN_DATA_IN                   <= '0;
      CONFIGURABLE_PIN_IRQ          <= 1'b0;
      SPI_MISO                      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      hw_cnt_reg     <= hw_cnt_next;
      poll_cnt_reg   <= poll_cnt_next;
      samp_reg       <= samp_next;
      held_reg       <= held_next;
      hold_reg       <= hold_next;
      pulse_reg      <= pulse_next;
      wake_prev_reg  <= wake_prev_next;
      blink_cnt_reg  <= blink_cnt_next;
      phase_reg      <= phase_next;
      act_tog_reg    <= act_tog_next;
      CPU_RESET      <= cpu_rst_next;
      RESTORE_DEFAULTS              <= restore_next;
      STANDBY_INDICATOR             <= standby_next;
      SYSTEM_INDICATOR              <= sys_ind_next;
      WIRELESS_INDICATOR_N          <= wifi_n_next;
      NET_SPEED_INDICATOR_N         <= speed_n_next;
      NET_LINK_ACTIVITY_INDICATOR_N <= link_n_next;
      CONFIGURABLE_PIN_O            <= pin_o_next;
      CONFIGURABLE_PIN_OE_N         <= pin_oe_n_next;
      PIN_DATA_IN                   <= pin_in_next;
      CONFIGURABLE_PIN_IRQ          <= irq_next;
      SPI_MISO                      <= miso_next;
    end
  end

endmodule

/* common/rdws_consts.svh */
// Constants of the reset, restore, wake and status block.
// Assumes a 100 MHz reference clock; times are held in milliseconds, the reboot pulse in cycles.
`ifndef RDWS_CONSTS_SVH
`define RDWS_CONSTS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define RDWS_CLK_KHZ          100000
`define RDWS_HW_REBOOT_MS     50
`define RDWS_HW_REBOOT_CYC    (`RDWS_HW_REBOOT_MS * `RDWS_CLK_KHZ)
`define RDWS_POLL_MS          10
`define RDWS_POLL_CYC         (`RDWS_POLL_MS * `RDWS_CLK_KHZ)
`define RDWS_RESTORE_HOLD_MS  6000
`define RDWS_RESTORE_POLLS    (`RDWS_RESTORE_HOLD_MS / `RDWS_POLL_MS)
`define RDWS_BLINK_START_MS   5000
`define RDWS_BLINK_POLLS      (`RDWS_BLINK_START_MS / `RDWS_POLL_MS)
`define RDWS_BLINK_HALF_MS    500
`define RDWS_BLINK_HALF_CYC   (`RDWS_BLINK_HALF_MS * `RDWS_CLK_KHZ)
`define RDWS_REBOOT_PULSE_CYC 16

// ****************************************************************
// Configurable pins
// ****************************************************************
`define RDWS_PIN_COUNT        13
`define RDWS_PIN_IRQ          1
`define RDWS_PIN_MISO         2
`define RDWS_PIN_MOSI         3
`define RDWS_PIN_SCK          6
`define RDWS_PIN_CS           7

// ****************************************************************
// Reset values
// ****************************************************************
`define RDWS_PINS_RST         13'h1fff
`define RDWS_SYS_IND_RST      1'b1

`endif

/* common/rdws_pkg.sv */
// Types shared by the reset, restore, wake and status block.
// Assumes rdws_consts.svh is on the include path.
`include "rdws_consts.svh"

package rdws_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [`RDWS_PIN_COUNT-1:0] rdws_pins_t;

  typedef enum logic [2:0] {
    S_RUN,
    S_ARMED,
    S_RESTORE,
    S_REBOOT,
    S_STANDBY,
    S_HWRST
  } rdws_state_e;

  // Serial-peripheral lines driven by the module
  typedef struct packed {
    logic mosi;
    logic sck;
    logic cs_n;
  } rdws_spi_s;

  // Wired network link status
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic activity;
  } rdws_net_s;

endpackage

/* dv/rdws_assertions.sv */
// Checker of the reset, restore, wake and indicator block.
// Bound to rdws_top; watches its ports only, one clock domain.
`timescale 1ns/1ps
module rdws_assertions
  import rdws_pkg::*;
#(
  parameter logic [31:0] HW_REBOOT_CYC = 32'd20,
  parameter logic [31:0] POLL_CYC      = 32'd4
) (
  input wire logic       REF_CLK,
  input wire logic       SRST,
  input wire logic       HW_REBOOT_N,
  input wire logic       FACTORY_RESTORE_N,
  input wire logic       WAKE,
  input wire logic       SLEEP_REQ,
  input wire logic       STA_ASSOCIATED,
  input wire rdws_net_s  NET_STATUS,
  input wire logic       SPI_ENABLE,
  input wire rdws_spi_s  SPI_OUT,
  input wire rdws_pins_t PIN_DIR_OUT,
  input wire rdws_pins_t CONFIGURABLE_PIN_I,
  input wire logic       CPU_RESET,
  input wire logic       RESTORE_DEFAULTS,
  input wire logic       STANDBY_INDICATOR,
  input wire logic       WIRELESS_INDICATOR_N,
  input wire logic       NET_SPEED_INDICATOR_N,
  input wire logic       NET_LINK_ACTIVITY_INDICATOR_N,
  input wire rdws_pins_t CONFIGURABLE_PIN_O,
  input wire rdws_pins_t CONFIGURABLE_PIN_OE_N,
  input wire logic       CONFIGURABLE_PIN_IRQ,
  input wire logic       SPI_MISO
);
  // ****************
  // Helper counters
  // ****************
  logic [31:0] lo_reg, lo_next, run_reg, run_next;
  logic [31:0] hi_reg, hi_next, last_reg, last_next;

  // Button run ignores highs shorter than a poll, as the filter does
  always_comb begin
    lo_next   = HW_REBOOT_N ? '0 : lo_reg + 32'd1;
    hi_next   = FACTORY_RESTORE_N ? hi_reg + 32'd1 : '0;
    last_next = (hi_reg == POLL_CYC) ? run_reg : last_reg;
    run_next  = (hi_reg >= POLL_CYC) ? '0 :
                run_reg + 32'(!FACTORY_RESTORE_N);
  end

  // Registers only
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      lo_reg   <= '0;
      hi_reg   <= '0;
      run_reg  <= '0;
      last_reg <= '0;
    end else begin
      lo_reg   <= lo_next;
      hi_reg   <= hi_next;
      run_reg  <= run_next;
      last_reg <= last_next;
    end
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  sequence s_released;
    FACTORY_RESTORE_N && $past(FACTORY_RESTORE_N, 2);
  endsequence
  sequence s_reboot;
    !RESTORE_DEFAULTS ##[0:1] CPU_RESET [*8];
  endsequence

  property p_hw_reboot;
    lo_reg == HW_REBOOT_CYC |-> CPU_RESET;
  endproperty
  a_hw_reboot: assert property (p_hw_reboot)
    else $error("reboot missing after long reset low");
  property p_hw_short;
    $rose(CPU_RESET) |-> lo_reg >= HW_REBOOT_CYC ||
      RESTORE_DEFAULTS || $past(RESTORE_DEFAULTS);
  endproperty
  a_hw_short: assert property (p_hw_short)
    else $error("reboot without cause");
  property p_restore_len;
    $rose(RESTORE_DEFAULTS) |-> last_reg >= 32'd598 * POLL_CYC;
  endproperty
  a_restore_len: assert property (p_restore_len)
    else $error("restore after too short a hold");
  property p_restore_boot;
    RESTORE_DEFAULTS |-> s_released ##1 s_reboot;
  endproperty
  a_restore_boot: assert property (p_restore_boot)
    else $error("restore not after release or no reboot");
  property p_sleep;
    $rose(STANDBY_INDICATOR) |-> $past(SLEEP_REQ) || $past(SLEEP_REQ, 2);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("standby without request");
  property p_wake;
    $fell(STANDBY_INDICATOR) |-> ($past(WAKE) && !$past(WAKE, 2))
      || lo_reg >= HW_REBOOT_CYC;
  endproperty
  a_wake: assert property (p_wake)
    else $error("standby left without wake edge");
  property p_wlan;
    !$past(SRST) |-> WIRELESS_INDICATOR_N == !$past(STA_ASSOCIATED);
  endproperty
  a_wlan: assert property (p_wlan)
    else $error("wireless indicator wrong");
  property p_speed;
    !$past(SRST) |-> NET_SPEED_INDICATOR_N ==
      !($past(NET_STATUS.link_up) && $past(NET_STATUS.speed_100));
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed indicator wrong");
  property p_link;
    !$past(SRST) && NET_STATUS.link_up && $past(NET_STATUS.link_up)
      |=> $changed(NET_LINK_ACTIVITY_INDICATOR_N) ==
          $past(NET_STATUS.activity);
  endproperty
  a_link: assert property (p_link)
    else $error("link indicator toggle wrong");
  property p_dir;
    !$past(SRST) && !$past(SPI_ENABLE) |->
      CONFIGURABLE_PIN_OE_N == ~$past(PIN_DIR_OUT);
  endproperty
  a_dir: assert property (p_dir)
    else $error("pin direction wrong");
  property p_spi;
    !$past(SRST) && $past(SPI_ENABLE) |->
      CONFIGURABLE_PIN_IRQ == $past(CONFIGURABLE_PIN_I[1]) &&
      SPI_MISO == $past(CONFIGURABLE_PIN_I[2]) &&
      CONFIGURABLE_PIN_O[3] == $past(SPI_OUT.mosi) &&
      (CONFIGURABLE_PIN_OE_N & 13'h00ce) == 13'h0006;
  endproperty
  a_spi: assert property (p_spi)
    else $error("serial pin roles wrong");
endmodule

/* dv/rdws_host.sv */
// Host board model: reboot driver and restore push-button.
// Both lines have pull-ups, so a released line reads high.
`timescale 1ns/1ps
module rdws_host (
  input  wire logic clk,
  output logic      restore_n,
  output logic      reboot_n
);
  // ****************
  // Drivers
  // ****************
  // Idle high from time zero
  initial begin
    restore_n = 1'b1;
    reboot_n  = 1'b1;
  end

  // Hold reboot low for n edges, then release high
  task automatic reboot(input int n);
    @(posedge clk);
    #1 reboot_n = 1'b0;
    repeat (n) @(posedge clk);
    #1 reboot_n = 1'b1;
  endtask

  // Press for n cycles; bounce high one cycle at glitch_at
  task automatic press(input int n, input int glitch_at);
    @(posedge clk);
    #1 restore_n = 1'b0;
    for (int i = 1; i < n; i++) begin
      @(posedge clk);
      #1 restore_n = (i == glitch_at);
    end
    @(posedge clk);
    #1 restore_n = 1'b1;
  endtask
endmodule

/* dv/rdws_top_bench.sv */
// Self-checking bench of the reset, restore, wake and status block.
// Counts shortened by parameters so restore runs in a few thousand cycles.
`timescale 1ns/1ps
module rdws_top_bench
  import rdws_pkg::*;
;
  // ****************
  // Signals
  // ****************
  localparam int HWC = 20;
  localparam int PC  = 4;
  localparam int BHC = 8;
  typedef struct packed {
    logic sta, link, spd, w_n, s_n;
  } rdws_row_s;
  rdws_row_s  rows [4] = '{5'b11100, 5'b01011, 5'b10101, 5'b00011};
  logic       clk, srst, wake, sleep_req, sta, spi_en, restore_n;
  logic       reboot_n, cpu_rst, rst_def, stby, sys, wlan_n, spd_n;
  logic       lnk_n, irq, miso;
  rdws_net_s  net;
  rdws_spi_s  spi;
  rdws_pins_t dir, dout, pin_i, pin_o, oe_n, din;
  int         n_mismatch, n_compared, n_dark, n_rst, n_cpu, n_lit, i;

  rdws_top #(.HW_REBOOT_CYC(32'd20), .POLL_CYC(32'd4),
    .BLINK_HALF_CYC(32'd8)) rdws_top_inst (
    .REF_CLK(clk), .SRST(srst), .HW_REBOOT_N(reboot_n),
    .FACTORY_RESTORE_N(restore_n), .WAKE(wake), .SLEEP_REQ(sleep_req),
    .STA_ASSOCIATED(sta), .NET_STATUS(net), .SPI_ENABLE(spi_en),
    .SPI_OUT(spi), .PIN_DIR_OUT(dir), .PIN_DATA_OUT(dout),
    .CONFIGURABLE_PIN_I(pin_i), .CPU_RESET(cpu_rst),
    .RESTORE_DEFAULTS(rst_def), .STANDBY_INDICATOR(stby),
    .SYSTEM_INDICATOR(sys), .WIRELESS_INDICATOR_N(wlan_n),
    .NET_SPEED_INDICATOR_N(spd_n), .NET_LINK_ACTIVITY_INDICATOR_N(lnk_n),
    .CONFIGURABLE_PIN_O(pin_o), .CONFIGURABLE_PIN_OE_N(oe_n),
    .PIN_DATA_IN(din), .CONFIGURABLE_PIN_IRQ(irq), .SPI_MISO(miso));
  rdws_host rdws_host_inst (.clk(clk), .restore_n(restore_n),
    .reboot_n(reboot_n));

  // Clock, and event counters sampled at the edge
  always #5 clk = ~clk;
  // A lit half may only end by a blink toggle after a full half period
  always @(posedge clk) begin
    if (!sys) n_dark++;
    if (rst_def) n_rst++;
    if (cpu_rst) n_cpu++;
    if (sys) n_lit++;
    else if (n_lit != 0) begin
      chk(n_lit >= BHC, 1'b1);
      n_lit = 0;
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("ERROR %0t run did not finish", $time);
    give_verdict();
  end

  // ****************
  // Sequence
  // ****************
  initial begin
    {clk, srst, wake, sleep_req, sta, spi_en} = 6'b010000;
    {net, spi, dir, dout, pin_i} = '0;
    {n_mismatch, n_compared, n_dark, n_rst, n_cpu} = '0;
    tick(16);
    srst = 1'b0;
    chk(oe_n, 13'h1fff);
    chk(sys, 1'b1);
    // Table of indicator cases
    foreach (rows[k]) begin
      sta = rows[k].sta;
      net = '{link_up: rows[k].link, speed_100: rows[k].spd, activity: 1'b0};
      tick(2);
      chk(wlan_n, rows[k].w_n);
      chk(spd_n, rows[k].s_n);
    end
    // Link solid low, then one activity pulse toggles it
    net.link_up = 1'b1;
    tick(2);
    chk(lnk_n, 1'b0);
    net.activity = 1'b1;
    tick(1);
    net.activity = 1'b0;
    tick(1);
    chk(lnk_n, 1'b1);
    // Plain pins, then serial roles override direction
    dir = 13'h0a5a;
    dout = 13'h1234;
    pin_i = 13'h0f0b;
    tick(2);
    chk(oe_n, 13'h15a5);
    chk(pin_o & dir, 13'h0210);
    chk(din, 13'h0f0b);
    chk({irq, miso}, 2'b00);
    spi_en = 1'b1;
    spi = '{mosi: 1'b1, sck: 1'b0, cs_n: 1'b1};
    tick(2);
    chk(oe_n & 13'h00ce, 13'h0006);
    chk(pin_o & 13'h00c8, 13'h0088);
    chk({irq, miso}, 2'b10);
    spi_en = 1'b0;
    // Reboot one cycle short, then exactly long enough
    rdws_host_inst.reboot(HWC - 1);
    chk(cpu_rst, 1'b0);
    rdws_host_inst.reboot(HWC);
    chk(cpu_rst, 1'b1);
    tick(3);
    chk(cpu_rst, 1'b0);
    // Standby entry and wake
    sleep_req = 1'b1;
    tick(1);
    sleep_req = 1'b0;
    tick(3);
    chk(stby, 1'b1);
    wake = 1'b1;
    tick(3);
    chk(stby, 1'b0);
    wake = 1'b0;
    // Short holds: no blink, then blink but no restore
    n_dark = 0;
    rdws_host_inst.press(480 * PC, 0);
    tick(12 * PC);
    chk(n_dark, 0);
    rdws_host_inst.press(530 * PC, 0);
    tick(12 * PC);
    chk(n_dark > 0, 1'b1);
    chk({n_rst != 0, sys}, 2'b01);
    // Long hold with a bounce mid-way, then restore and reboot
    n_cpu = 0;
    rdws_host_inst.press(620 * PC, 300 * PC);
    for (i = 0; i < 100 && n_rst == 0; i++)
      tick(1);
    chk(n_rst, 1);
    if (i == 100)
      give_verdict();
    tick(30);
    chk(n_cpu, 16);
    give_verdict();
  end
endmodule

bind rdws_top rdws_assertions #(.HW_REBOOT_CYC(HW_REBOOT_CYC),
  .POLL_CYC(POLL_CYC)) rdws_assertions_inst (.*);
